//--- src/status_word_pkg.sv
`default_nettype none
package status_word_pkg;
    // ==========================================
    // Status word layout
    localparam logic [3:0] bit_busy = 4'h0;
    localparam logic [3:0] bit_rd_done = 4'h1;
    localparam logic [3:0] bit_wr_done = 4'h2;
    localparam logic [3:0] bit_invalid = 4'h3;
    localparam logic [3:0] bit_conv_err = 4'h4;
    localparam logic [3:0] bit_speed = 4'h5;
    localparam logic [3:0] bit_limit = 4'h8;
    localparam logic [3:0] bit_ext_pwr = 4'h9;
    localparam logic [3:0] bit_pulse = 4'hb;
    localparam logic [3:0] bit_ok = 4'hc;
    localparam logic [3:0] status_offset = 4'h1;
    localparam logic [15:0] status_reset = 16'h0000;
    // ==========================================
    // Timing
    localparam int clk_hz = 40000000;
    localparam int half_period_ms = 500;
    localparam int half_period_cycles = clk_hz / 1000 * half_period_ms;
    localparam int nv_gap_ms = 100;
    localparam int nv_gap_cycles = clk_hz / 1000 * nv_gap_ms;
endpackage
`default_nettype wire

//--- src/heartbeat_gen.sv
`timescale 1ns/1ps
`default_nettype none
module heartbeat_gen #(
    parameter int half_cycles = status_word_pkg::half_period_cycles
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hold,
    output logic pulse
);
    import status_word_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic level;
    } hb_state_t;
    hb_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        // Frozen during nonvolatile writes; phase resumes where it stopped
        if (!hold) begin
            if (s_q.cnt >= 32'(half_cycles - 1)) begin
                s_d.cnt = 32'h0;
                s_d.level = ~s_q.level;
            end else begin
                s_d.cnt = s_q.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.level;
endmodule
`default_nettype wire

//--- src/analog_out_status_word.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Busy, read-complete, write-complete bits 0..2 follow host block transfers.
// - Bit 3 sets on invalid write data, clears on later valid write.
// - Bit 4 sets on conversion error, clears on later valid write.
// - Faulty data is discarded; previous configuration is kept.
// - Bit 5 shows speed mode: low normal, high high-speed.
// - Bit 8 sets on out-of-limit data, clears on in-range data.
// - Bit 9 is high while external supply is present.
// - Bit 11 is a 1 Hz, 50 percent heartbeat.
// - Heartbeat pauses during nonvolatile write, resumes after.
// - Bit 12 sets on self-test pass, clears on internal error.
// - Nonvolatile-write command starts a timed nv_busy run; host spaces commands 100 ms.
// - Write data ignored unless host write-done notification is raised.
module analog_out_status_word
    import status_word_pkg::*;
#(
    parameter int half_cycles = status_word_pkg::half_period_cycles,
    parameter int nv_write_cycles = 1000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic host_post_done,
    input wire logic block_write_instruction,
    input wire logic [15:0] write_data,
    input wire logic data_invalid,
    input wire logic conv_error,
    input wire logic data_over_limit,
    input wire logic speed_high,
    input wire logic ext_supply_on,
    input wire logic diag_pass,
    input wire logic diag_fail,
    input wire logic nv_write_cmd,
    input wire logic xfer_busy,
    input wire logic xfer_read_done,
    input wire logic xfer_write_done,
    output logic [15:0] module_status_word,
    output logic [15:0] config_word,
    output logic nv_busy
);
    import status_word_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] cfg;
        logic invalid;
        logic conv_err;
        logic limit;
        logic ok;
        logic nv_cmd_prev;
        logic nv_active;
        logic [31:0] nv_cnt;
    } sw_state_t;
    sw_state_t s_q, s_d;
    logic pulse;
    logic write_take;
    logic write_bad;

    // ==========================================
    // Helpers
    // Invalid or conversion-error data must never reach the configuration; over-limit data still does
    function automatic logic write_faulty(
        input logic invalid_in,
        input logic conv_in
    );
        return invalid_in || conv_in;
    endfunction

    // Sticky flag; an event in the same cycle as its clear wins
    function automatic logic sticky_flag(
        input logic flag_in,
        input logic set_in,
        input logic clr_in
    );
        logic flag_out;
        flag_out = flag_in;
        if (clr_in) begin
            flag_out = 1'b0;
        end
        if (set_in) begin
            flag_out = 1'b1;
        end
        return flag_out;
    endfunction

    // True on the last cycle of a timed run
    function automatic logic run_done(
        input logic [31:0] cnt_in,
        input int run_cycles
    );
        return cnt_in >= 32'(run_cycles - 1);
    endfunction

    // Reserved positions stay at their reset value of zero
    function automatic logic [15:0] pack_status(
        input logic busy_in,
        input logic rd_done_in,
        input logic wr_done_in,
        input logic invalid_in,
        input logic conv_in,
        input logic speed_in,
        input logic limit_in,
        input logic supply_in,
        input logic pulse_in,
        input logic ok_in
    );
        logic [15:0] word;
        word = status_reset;
        word[bit_busy] = busy_in;
        word[bit_rd_done] = rd_done_in;
        word[bit_wr_done] = wr_done_in;
        word[bit_invalid] = invalid_in;
        word[bit_conv_err] = conv_in;
        word[bit_speed] = speed_in;
        word[bit_limit] = limit_in;
        word[bit_ext_pwr] = supply_in;
        word[bit_pulse] = pulse_in;
        word[bit_ok] = ok_in;
        return word;
    endfunction

    // ==========================================
    // Heartbeat
    // Hold comes from a register, so the freeze starts one clock after the command
    heartbeat_gen #(.half_cycles(half_cycles)) u_hb (
        .mclk(mclk),
        .rst_n(rst_n),
        .hold(s_q.nv_active),
        .pulse(pulse)
    );

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;

        // ==========================================
        // Write acceptance
        write_take = block_write_instruction && host_post_done;
        write_bad = write_faulty(data_invalid, conv_error);
        // Keep the old configuration rather than half-apply bad data
        if (write_take && !write_bad) begin
            s_d.cfg = write_data;
        end
        // Limit follows every taken write, faulty ones too
        if (write_take) begin
            s_d.limit = data_over_limit;
        end

        // ==========================================
        // Error and health flags
        s_d.invalid = sticky_flag(
            s_q.invalid,
            write_take && data_invalid,
            write_take && !write_bad
        );
        s_d.conv_err = sticky_flag(
            s_q.conv_err,
            conv_error,
            write_take && !write_bad
        );
        // Error wins over a pass seen in the same cycle
        s_d.ok = sticky_flag(
            s_q.ok,
            diag_pass && !diag_fail,
            diag_fail
        );

        // ==========================================
        // Nonvolatile write timer
        // Edge detect, so a held command starts one write only
        // A command edge during a run is dropped; spacing is the host's duty
        s_d.nv_cmd_prev = nv_write_cmd;
        if (s_q.nv_active) begin
            if (run_done(s_q.nv_cnt, nv_write_cycles)) begin
                s_d.nv_active = 1'b0;
                s_d.nv_cnt = 32'h0;
            end else begin
                s_d.nv_cnt = s_q.nv_cnt + 32'h1;
            end
        end else if (nv_write_cmd && !s_q.nv_cmd_prev) begin
            s_d.nv_active = 1'b1;
            s_d.nv_cnt = 32'h0;
        end

        // ==========================================
        // Status word
        // Mirrored transfer bits lag their inputs by one clock
        s_d.status = pack_status(
            xfer_busy,
            xfer_read_done,
            xfer_write_done,
            s_d.invalid,
            s_d.conv_err,
            speed_high,
            s_d.limit,
            ext_supply_on,
            pulse,
            s_d.ok
        );
    end

    // ==========================================
    // Registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    // All outputs come straight from the state register
    assign module_status_word = s_q.status;
    assign config_word = s_q.cfg;
    assign nv_busy = s_q.nv_active;
endmodule
`default_nettype wire

//--- sim/status_word_props.sv
`timescale 1ns/1ps
`default_nettype none
module status_word_props (
    input wire logic mclk, rst_n, host_post_done, block_write_instruction, data_invalid,
    input wire logic conv_error, data_over_limit, diag_fail, nv_write_cmd, nv_busy,
    input wire logic [15:0] write_data, module_status_word, config_word
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic tk = block_write_instruction && host_post_done;
    wire logic [15:0] s = module_status_word;
    // Busy for exactly the run length, then free again
    sequence nv_run;
        nv_busy [*4] ##1 !nv_busy;
    endsequence
    a_res_zero: assert property ((s & 16'he4c0) == 16'h0000) else $error("reserved set");
    a_invalid_set: assert property (tk && data_invalid |=> s[3]) else $error("invalid");
    a_clean_write: assert property (tk && !data_invalid && !conv_error |=>
        !s[3] && !s[4] && config_word == $past(write_data)) else $error("clean write");
    a_keep_config: assert property (tk && data_invalid |=> $stable(config_word)) else $error("kept");
    a_ignore_write: assert property (!host_post_done |=> $stable(config_word)) else $error("ign");
    a_limit_flag: assert property (tk |=> s[8] == $past(data_over_limit)) else $error("limit");
    a_conv_set: assert property (conv_error |=> s[4]) else $error("conv");
    a_ok_clear: assert property (diag_fail |=> !s[12]) else $error("ok");
    a_nv_run: assert property ($rose(nv_write_cmd) && !nv_busy |=> nv_run) else $error("nv");
    a_pulse_hold: assert property (nv_busy && $past(nv_busy) |=> $stable(s[11])) else $error("pulse");
endmodule
bind analog_out_status_word status_word_props u_props (.*);
`default_nettype wire

//--- sim/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    output logic host_post_done, block_write_instruction, data_invalid, data_over_limit, nv_write_cmd,
    output logic [15:0] write_data
);
    initial {host_post_done, block_write_instruction, data_invalid, data_over_limit, nv_write_cmd, write_data} = '0;
    // A released bus shows the inverse so no stale word passes
    task automatic put(input logic st, pd, input logic [15:0] d, input logic inv, ol);
        block_write_instruction = st;
        host_post_done = pd;
        write_data = st ? d : ~write_data;
        {data_invalid, data_over_limit} = {inv, ol};
    endtask
    task automatic nv(input logic v);
        nv_write_cmd = v;
    endtask
endmodule
`default_nettype wire

//--- sim/test_analog_out_status_word.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: %h %h", $time, a, b); end end
module test_analog_out_status_word;
    import status_word_pkg::*;
    logic mclk, rst_n, conv_error, speed_high, ext_supply_on, diag_pass, diag_fail;
    logic xfer_busy, xfer_read_done, xfer_write_done, fi, fc, fl, fo, s;
    wire logic host_post_done, block_write_instruction, data_invalid, data_over_limit, nv_write_cmd, nv_busy;
    wire logic [15:0] write_data, module_status_word, config_word;
    logic [15:0] e_cfg, e_sw, wd;
    logic [4:0] r;
    int num_errors = 0, compares = 0, n;
    host_cpu_model host (.*);
    analog_out_status_word #(.half_cycles(8), .nv_write_cycles(4)) uut (.*);
    function automatic logic [15:0] expect_word();
        return {3'b0, fo, 2'b0, ext_supply_on, fl, 2'b0, speed_high, fc, fi, xfer_write_done, xfer_read_done, xfer_busy};
    endfunction
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #10000;
        num_errors++;
        print_verdict();
    end
    initial begin
        {rst_n, conv_error, speed_high, ext_supply_on, diag_pass, diag_fail, xfer_busy, xfer_read_done, xfer_write_done} = '0;
        {e_cfg, fi, fc, fl, fo} = '0;
        void'($urandom(32'ha45d));
        repeat (5) @(posedge mclk);
        `CHK(module_status_word, status_reset)
        #1 rst_n = 1;
        @(posedge mclk);
        #1;
        for (n = 0; n < 60; n++) begin
            {speed_high, ext_supply_on, xfer_busy, xfer_read_done, xfer_write_done, diag_pass, diag_fail} = 7'($urandom);
            r = n == 0 ? 5'h01 : n == 1 ? 5'h07 : 5'($urandom);
            wd = 16'($urandom);
            host.put(r[0], r[1], wd, r[2], r[3]);
            conv_error = r[4] && !(r[0] && r[1]);
            if (r[0] && r[1]) begin
                fl = r[3];
                if (r[2]) fi = 1;
                else {fi, fc, e_cfg} = {2'b0, wd};
            end
            if (conv_error) fc = 1;
            if (diag_fail) fo = 0;
            else if (diag_pass) fo = 1;
            e_sw = expect_word();
            @(posedge mclk);
            #1 `CHK(module_status_word & 16'hf7ff, e_sw)
            `CHK(config_word, e_cfg)
        end
        host.put(0, 0, 16'h0000, 0, 0);
        n = 0;
        repeat (32) begin
            s = module_status_word[11];
            @(posedge mclk);
            #1 n += int'(s != module_status_word[11]);
        end
        `CHK(n, 4)
        host.nv(1);
        @(posedge mclk);
        #1 host.nv(0);
        n = int'(nv_busy);
        repeat (8) begin
            @(posedge mclk);
            #1 n += int'(nv_busy);
        end
        `CHK(n, 4)
        print_verdict();
    end
endmodule
`default_nettype wire
